// ==== logic/sfp_link.sv ====
// serial clock side: shifts in opcode and argument, shifts out status
// assumes the host clocks sck only while chip select is low
`timescale 1ns/1ps
`default_nettype none
module sfp_link
    import sfp_pkg::*;
(
    input  wire logic  sck,
    input  wire logic  cs_n,
    input  wire logic  si,
    output logic       so,
    sfp_link_if.link   lnk
);
    logic             fresh;
    logic [2:0]       bit_cnt;
    logic [6:0]       shift;
    logic [2:0]       next_bit_cnt;
    logic [6:0]       next_shift;
    logic [7:0]       next_op;
    logic [7:0]       next_arg;
    logic [1:0]       next_bcount;
    logic [7:0]       full_byte;
    logic             send;

    ////////////////////////////////////////////////////////////////////////
    // frame start marker, set while deselected
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            fresh <= 1'b1;
        end else begin
            fresh <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive on rising edge, msb first
    always_comb begin
        logic [2:0] bc;
        logic [1:0] cnt;
        bc          = fresh ? 3'h0 : bit_cnt;                       // R12
        cnt         = fresh ? 2'h0 : lnk.byte_count;                // R12
        full_byte   = {shift, si};                                  // R10
        next_shift  = {shift[5:0], si};
        next_bit_cnt = bc + 3'h1;
        next_op     = lnk.op_byte;
        next_arg    = lnk.arg_byte;
        next_bcount = cnt;
        if (bc == LAST_BIT) begin
            if (cnt == 2'h0) begin
                next_op = full_byte;
            end
            if (cnt == 2'h1) begin
                next_arg = full_byte;
            end
            if (cnt != BYTES_WITH_ARG) begin
                next_bcount = cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge sck) begin
        if (!cs_n) begin                                            // R3
            bit_cnt        <= next_bit_cnt;                         // R1
            shift          <= next_shift;
            lnk.op_byte    <= next_op;
            lnk.arg_byte   <= next_arg;
            lnk.byte_count <= next_bcount;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit on falling edge; only status read answers
    assign send = !fresh && (lnk.byte_count != 2'h0) && (lnk.op_byte == OP_READ_STATUS);

    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            so <= 1'b0;
        end else begin
            so <= send ? lnk.status_byte[LAST_BIT - bit_cnt] : 1'b0; // R2
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_opcode_capture: assert property (@(posedge sck) disable iff (cs_n) // R1
        (!fresh && bit_cnt == 3'h7 && lnk.byte_count == 2'h0)
            |=> lnk.op_byte == $past({shift, si}))
        else $error("opcode not captured on rising edge");
    a_frame_restart: assert property (@(posedge sck) disable iff (cs_n) // R12
        fresh |=> (bit_cnt == 3'h1 && lnk.byte_count == 2'h0))
        else $error("bit counter not restarted at selection");
    a_quiet_opcode: assert property (@(posedge sck) disable iff (cs_n) // R2
        (lnk.byte_count == 2'h0) |-> !so)
        else $error("output moved during opcode");
endmodule // sfp_link
`default_nettype wire

// ==== logic/sfp_link_if.sv ====
// words passed between the serial-clock logic and the system-clock core
// assumes words are read only while the frame is closed or frozen
`timescale 1ns/1ps
`default_nettype none
interface sfp_link_if;
    import sfp_pkg::*;
    logic [7:0] op_byte;
    logic [7:0] arg_byte;
    logic [1:0] byte_count;
    logic [7:0] status_byte;
    modport link (output op_byte, output arg_byte, output byte_count, input status_byte);
    modport core (input op_byte, input arg_byte, input byte_count, output status_byte);
endinterface
`default_nettype wire

// ==== logic/sfp_pkg.sv ====
// constants shared by the serial flash pin front end and its link logic
// assumes opcode values are local choices; the memory core lies elsewhere
package sfp_pkg;
    localparam int unsigned BYTE_W         = 8;
    localparam int unsigned SECTORS        = 8;
    localparam int unsigned SECTOR_W       = 3;
    localparam int unsigned CNT_W          = 3;
    localparam int unsigned BCNT_W         = 2;
    localparam int unsigned SYNC_N         = 3;
    // opcode values are local choices
    localparam logic [7:0]  OP_PROGRAM     = 8'h02;
    localparam logic [7:0]  OP_ERASE       = 8'h20;
    localparam logic [7:0]  OP_MAP_WRITE   = 8'h3F;
    localparam logic [7:0]  OP_PROT_ON     = 8'h2A;
    localparam logic [7:0]  OP_PROT_OFF    = 8'h2B;
    localparam logic [7:0]  OP_READ_STATUS = 8'hD7;
    localparam logic [2:0]  LAST_BIT       = 3'h7;
    localparam logic [1:0]  BYTES_WITH_ARG = 2'h2;
    localparam logic [7:0]  MAP_RESET      = 8'h00;
    localparam logic        PROT_EN_RESET  = 1'b0;
    localparam logic [2:0]  SYNC_RESET     = 3'h7;
    // status byte fields
    localparam int unsigned ST_WP_BIT      = 7;
    localparam int unsigned ST_PROT_BIT    = 6;
    typedef enum logic [1:0] {
        SFP_IDLE  = 2'b00,
        SFP_SEL   = 2'b01,
        SFP_EXEC  = 2'b11,
        SFP_FLUSH = 2'b10
    } sfp_state_type;
endpackage

// ==== logic/sfp_top.sv ====
// serial flash pin front end: chip select framing, write guard, protection map
// assumes a memory core takes op_valid pulses; sck is a separate clock
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [R1] capture input bits on serial clock rising edge
// [R2] change output bit on serial clock falling edge
// [R3] ignore serial input while chip select high
// [R4] release output whenever chip select is high
// [R5] guard pin low shields mapped sectors
// [R6] guard pin low locks the protection map
// [R7] program or erase under guard is discarded
// [R8] floating guard pin reads as high
// [R9] host frames each operation with chip select
// [R10] opcode first, all fields most significant first
// [R11] reset pin low aborts and holds idle
// [R12] new selection clears bit counter and decoder
module sfp_top
    import sfp_pkg::*;
#(
    parameter int unsigned NUM_SECTORS = SECTORS
)(
    input  wire logic                mclk,
    input  wire logic                resetn,
    input  wire logic                sck,
    input  wire logic                cs_n,
    input  wire logic                si,
    output logic                     so,
    output logic                     so_oe_n,
    input  wire logic                wp_n,
    input  wire logic                rst_pin_n,
    output logic                     op_valid,
    output logic                     op_erase,
    output logic [SECTOR_W-1:0]      op_sector,
    output logic                     op_refused,
    output logic                     prot_en,
    output logic [NUM_SECTORS-1:0]   prot_map
);
    sfp_link_if                      lnk ();
    logic [SYNC_N-1:0]               pins;
    logic [SYNC_N-1:0]               sync1;
    logic [SYNC_N-1:0]               sync2;
    logic                            cs_sync;
    logic                            wp_sync;
    logic                            rst_sync;
    sfp_state_type                   state;
    sfp_state_type                   next_state;
    logic                            next_valid;
    logic                            next_erase;
    logic [SECTOR_W-1:0]             next_sector;
    logic                            next_refused;
    logic                            next_prot_en;
    logic [NUM_SECTORS-1:0]          next_map;
    logic [7:0]                      status;
    logic [7:0]                      next_status;
    logic                            is_pe;
    logic                            guarded;

    ////////////////////////////////////////////////////////////////////////
    // serial clock side
    sfp_link u_link (
        .sck  (sck),
        .cs_n (cs_n),
        .si   (si),
        .so   (so),
        .lnk  (lnk.link)
    );

    assign so_oe_n         = cs_n;                                  // R4
    assign lnk.status_byte = status;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers; idle level is high for all three
    // a floating guard pin is pulled high outside, so it reads inactive
    assign pins = {rst_pin_n, wp_n, cs_n};                          // R8

    for (genvar i = 0; i < SYNC_N; i++) begin : g_sync
        always_ff @(posedge mclk) begin
            if (!resetn) begin
                sync1[i] <= SYNC_RESET[i];
                sync2[i] <= SYNC_RESET[i];
            end else begin
                sync1[i] <= pins[i];
                sync2[i] <= sync1[i];
            end
        end
    end

    assign cs_sync  = sync2[0];
    assign wp_sync  = sync2[1];
    assign rst_sync = sync2[2];

    ////////////////////////////////////////////////////////////////////////
    // command decode at frame end
    // link words are only read after chip select is seen high, when sck is still
    assign is_pe   = (lnk.op_byte == OP_PROGRAM) || (lnk.op_byte == OP_ERASE);
    assign guarded = prot_map[lnk.arg_byte[SECTOR_W-1:0]] && (prot_en || !wp_sync); // R5

    always_comb begin
        next_state   = state;
        next_valid   = 1'b0;
        next_erase   = op_erase;
        next_sector  = op_sector;
        next_refused = 1'b0;
        next_prot_en = prot_en;
        next_map     = prot_map;
        next_status  = status;
        unique case (state)
            SFP_IDLE: begin
                // snapshot frozen while selected, so the link sees a still word
                next_status = 8'h00;
                next_status[ST_WP_BIT]   = wp_sync;
                next_status[ST_PROT_BIT] = prot_en;
                if (!cs_sync) begin                                 // R9
                    next_state = SFP_SEL;
                end
            end
            SFP_SEL: begin
                if (cs_sync) begin
                    next_state = SFP_EXEC;
                end
            end
            SFP_EXEC: begin
                next_state = SFP_IDLE;
                // without its argument byte the argument word is stale, so drop it
                if (lnk.byte_count == BYTES_WITH_ARG) begin         // R10
                    if (is_pe) begin
                        if (!wp_sync || guarded) begin              // R7
                            next_refused = 1'b1;
                        end else begin
                            next_valid  = 1'b1;
                            next_erase  = (lnk.op_byte == OP_ERASE);
                            next_sector = lnk.arg_byte[SECTOR_W-1:0];
                        end
                    end else if (lnk.op_byte == OP_MAP_WRITE) begin
                        if (!wp_sync) begin                         // R6
                            next_refused = 1'b1;
                        end else begin
                            next_map = lnk.arg_byte[NUM_SECTORS-1:0];
                        end
                    end
                end
                if (lnk.byte_count != 2'h0) begin                   // R10
                    if (lnk.op_byte == OP_PROT_ON) begin
                        next_prot_en = 1'b1;
                    end else if (lnk.op_byte == OP_PROT_OFF) begin
                        next_prot_en = 1'b0;
                    end
                end
            end
            SFP_FLUSH: begin
                // a frame cut by the reset pin is dropped whole
                if (cs_sync) begin
                    next_state = SFP_IDLE;
                end
            end
        endcase
        if (!rst_sync) begin                                        // R11
            next_state   = SFP_FLUSH;
            next_valid   = 1'b0;
            next_refused = 1'b0;
            next_map     = prot_map;
            next_prot_en = prot_en;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state      <= SFP_IDLE;
            op_valid   <= 1'b0;
            op_erase   <= 1'b0;
            op_sector  <= '0;
            op_refused <= 1'b0;
            prot_en    <= PROT_EN_RESET;
            prot_map   <= MAP_RESET[NUM_SECTORS-1:0];
            status     <= 8'h00;
        end else begin
            state      <= next_state;
            op_valid   <= next_valid;
            op_erase   <= next_erase;
            op_sector  <= next_sector;
            op_refused <= next_refused;
            prot_en    <= next_prot_en;
            prot_map   <= next_map;
            status     <= next_status;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_output_release: assert property (@(posedge mclk) disable iff (!resetn) // R4
        cs_n |-> (so_oe_n && !so))
        else $error("output driven while deselected");
    a_guard_discards: assert property (@(posedge mclk) disable iff (!resetn) // R7
        (state == SFP_EXEC && rst_sync && !wp_sync && is_pe && lnk.byte_count == BYTES_WITH_ARG)
            |=> (op_refused && !op_valid))
        else $error("program or erase ran under guard");
    a_map_locked: assert property (@(posedge mclk) disable iff (!resetn) // R6
        !wp_sync |=> $stable(prot_map))
        else $error("protection map changed under guard");
    a_sector_shield: assert property (@(posedge mclk) disable iff (!resetn) // R5
        op_valid |-> !(prot_map[op_sector] && (prot_en || !$past(wp_sync))))
        else $error("protected sector released to core");
    a_reset_holds: assert property (@(posedge mclk) disable iff (!resetn) // R11
        !rst_sync |=> (state == SFP_FLUSH && !op_valid))
        else $error("reset pin did not hold idle");
    a_single_pulse: assert property (@(posedge mclk) disable iff (!resetn) // R10
        op_valid |=> !op_valid [*2])
        else $error("operation pulse repeated");
endmodule // sfp_top
`default_nettype wire

// ==== tb/sfp_host.sv ====
// host model: frames a transfer, clocks it and collects the reply
// assumes the bench resolves the data-out wire into so_pin
`timescale 1ns/1ps
`default_nettype none
module sfp_host (
    output logic      sck,
    output logic      cs_n,
    output logic      si,
    input  wire logic so_pin
);
    initial begin
        sck  = 1'b0;
        si   = 1'b0;
        // raise select once the device's processes wait, so its frame marker starts set
        #1;
        cs_n = 1'b1;
    end
    // clock stands still between frames, as a real host would leave it
    task automatic frame(input logic [15:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        #3;
        cs_n = 1'b0;
        #7;
        for (int i = 0; i < nbits; i++) begin
            si = (i < 16) ? tx[15 - i] : ~si;
            #3 sck = 1'b1;
            if (i >= 8 && i < 16) rx = {rx[6:0], so_pin};
            #3 sck = 1'b0;
        end
        #5 cs_n = 1'b1;
        // data line is flipped once after deselect so a deselected device has something to ignore
        si = ~si;
    endtask
endmodule // sfp_host
`default_nettype wire

// ==== tb/tb_sfp_top.sv ====
// bench for the pin front end: host model on the link, guard and reset pins
// assumes the pull-up on the guard pin is modelled here
`timescale 1ns/1ps
`default_nettype none
module tb_sfp_top;
    import sfp_pkg::*;
    logic       mclk;
    logic       resetn;
    logic       wp_n_drv;
    logic       wp_float;
    logic       rst_pin_n;
    logic       m_pe;
    logic [7:0] m_map;
    wire logic  sck;
    wire logic  cs_n;
    wire logic  si;
    logic       so;
    logic       so_oe_n;
    logic       op_valid;
    logic       op_erase;
    logic [2:0] op_sector;
    logic       op_refused;
    logic       prot_en;
    logic [7:0] prot_map;
    int         n_fail = 0;
    int         compares = 0;
    int         n_valid = 0;
    int         n_ref = 0;
    int         cycles = 0;
    logic [7:0] ops [6] = '{OP_PROGRAM, OP_ERASE, OP_MAP_WRITE, OP_PROT_ON, OP_PROT_OFF,
                            OP_READ_STATUS};
    wire logic  wp_n = wp_float ? 1'b1 : wp_n_drv;
    wire logic  so_pin = so_oe_n ? 1'bz : so;
    ////////////////////////////////////////////////////////////////////////////////////////
    sfp_top i_sfp_top (.mclk(mclk), .resetn(resetn), .sck(sck), .cs_n(cs_n), .si(si),
        .so(so), .so_oe_n(so_oe_n), .wp_n(wp_n), .rst_pin_n(rst_pin_n),
        .op_valid(op_valid), .op_erase(op_erase), .op_sector(op_sector),
        .op_refused(op_refused), .prot_en(prot_en), .prot_map(prot_map));
    sfp_host i_sfp_host (.sck(sck), .cs_n(cs_n), .si(si), .so_pin(so_pin));
    initial mclk = 1'b0;
    always #10 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (op_valid === 1'b1) n_valid++;
        if (op_refused === 1'b1) n_ref++;
        if (cs_n === 1'b1) check({7'h00, so_pin === 1'bz}, 8'h01);
        if (cycles == 6000) begin
            n_fail++;
            complete_run();
        end
    end
    // guard synchronisers need a few system clocks before the level counts
    task automatic set_wp(input logic v);
        @(posedge mclk) wp_n_drv <= v;
        repeat (6) @(posedge mclk);
    endtask
    task automatic do_cmd(input logic [7:0] op, input logic [7:0] arg, input int nbits);
        logic [7:0] rx;
        logic       wp;
        logic       full;
        logic       pe;
        logic       er;
        logic       ev;
        wp = wp_n;
        full = (nbits >= 16) && rst_pin_n;
        pe = (op == OP_PROGRAM) || (op == OP_ERASE);
        er = full && ((pe && (!wp || (m_pe && m_map[arg[2:0]]))) || (op == OP_MAP_WRITE && !wp));
        ev = full && pe && !er;
        n_valid = 0;
        n_ref = 0;
        i_sfp_host.frame({op, arg}, nbits, rx);
        repeat (8) @(posedge mclk);
        check(8'(n_valid), {7'h00, ev});
        check(8'(n_ref), {7'h00, er});
        if (ev) check({op_erase, 4'h0, op_sector}, {op == OP_ERASE, 4'h0, arg[2:0]});
        if (full && op == OP_MAP_WRITE && wp) m_map = arg;
        if (full && op == OP_PROT_ON) m_pe = 1'b1;
        if (full && op == OP_PROT_OFF) m_pe = 1'b0;
        check(prot_map, m_map);
        check({7'h00, prot_en}, {7'h00, m_pe});
        if (op == OP_READ_STATUS && full) check(rx, {wp, m_pe, 6'h00});
    endtask
    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        resetn = 1'b0;
        wp_n_drv = 1'b1;
        wp_float = 1'b0;
        rst_pin_n = 1'b1;
        m_pe = PROT_EN_RESET;
        m_map = MAP_RESET;
        void'($urandom(32'h82e6));
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        check(prot_map, MAP_RESET);
        do_cmd(OP_MAP_WRITE, 8'hA5, 16);
        do_cmd(OP_PROT_ON, 8'h00, 16);
        do_cmd(OP_PROGRAM, 8'h00, 16);
        do_cmd(OP_ERASE, 8'h01, 16);
        set_wp(1'b0);
        do_cmd(OP_MAP_WRITE, 8'h0F, 16);
        do_cmd(OP_PROGRAM, 8'h03, 16);
        do_cmd(OP_READ_STATUS, 8'h00, 24);
        set_wp(1'b1);
        do_cmd(OP_PROGRAM, 8'h06, 12);
        do_cmd(OP_PROGRAM, 8'h06, 16);
        @(posedge mclk) rst_pin_n <= 1'b0;
        repeat (4) @(posedge mclk);
        do_cmd(OP_ERASE, 8'h02, 16);
        @(posedge mclk) rst_pin_n <= 1'b1;
        repeat (4) @(posedge mclk);
        do_cmd(OP_ERASE, 8'h02, 16);
        @(posedge mclk) begin
            wp_float <= 1'b1;
            wp_n_drv <= 1'b0;
        end
        repeat (6) @(posedge mclk);
        do_cmd(OP_READ_STATUS, 8'h00, 16);
        @(posedge mclk) wp_float <= 1'b0;
        for (int i = 0; i < 40; i++) begin
            set_wp($urandom_range(0, 3) != 0);
            do_cmd(ops[$urandom_range(0, 5)], 8'($urandom), 16);
        end
        complete_run();
    end
endmodule // tb_sfp_top
`default_nettype wire
